// File: hdl/ddm_consts.svh
// Constants for the dual 8b10b decoder and multiplier block
`ifndef DDM_CONSTS_SVH
`define DDM_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define DDM_OFS_STATUS  4'h0
`define DDM_OFS_MASK    4'h4
`define DDM_OFS_DATA    4'h8
`define DDM_OFS_PROD    4'hc

// Status and mask field positions
`define DDM_BIT_A_LOCK  0
`define DDM_BIT_A_LOST  1
`define DDM_BIT_B_LOCK  2
`define DDM_BIT_B_LOST  3
`define DDM_EVT_W       4

// Reset values
`define DDM_MASK_RST    4'h0
`define DDM_STATUS_RST  4'h0

// Comma patterns in transmission order a..j, both running disparities
`define DDM_COMMA_NEG   10'h0fa
`define DDM_COMMA_POS   10'h305

// Symbol timing: ten line bits per symbol, last bit index
`define DDM_SYM_LAST    4'h9

`endif

// File: hdl/ddm_pkg.sv
// Types for the dual 8b10b decoder and multiplier block
package ddm_pkg;

  // Per-lane alignment state
  typedef enum logic {
    DDM_HUNT,
    DDM_LOCKED
  } ddm_lane_state_t;

  // Output view chosen by the selection pins
  typedef enum logic [2:0] {
    DDM_VIEW_STATUS,
    DDM_VIEW_PROD,
    DDM_VIEW_PROD_GATED,
    DDM_VIEW_DEC_REG,
    DDM_VIEW_DEC_UNREG
  } ddm_view_t;

endpackage

// File: hdl/ddm_top.sv
// Dual 8b10b receive decoder with byte multiplier and pin views
//
// What this block does
// - Hunt for either-disparity comma after reset
// - Comma found sets valid; data symbols update byte
// - Comma while valid keeps valid, holds byte
// - Bad symbol drops valid, back to hunting
// - In reset, pins mirror inputs as differential pairs
// - Outside reset, eighth input drives bidir enables
// - Multiply decoded bytes; selection picks data or product
// - Views: status, product, gated product, registered, unregistered
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ddm_consts.svh"

module ddm_top
  import ddm_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  input  wire logic        line_a_in,
  input  wire logic        line_b_in,
  input  wire logic        sel_status_in,
  input  wire logic        sel_prod_in,
  input  wire logic        sel_prod_gated_in,
  input  wire logic        sel_dec_reg_in,
  input  wire logic        sel_dec_unreg_in,
  input  wire logic        bidir_drive_in,
  output logic      [7:0]  out_pins_out,
  output logic      [7:0]  bidir_out,
  output logic      [7:0]  bidir_oe_n_out,
  input  wire logic [1:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // 6b sub-block abcdei to EDCBA, top bit flags a legal code
  function automatic logic [5:0] dec6(input logic [5:0] c);
    case (c)
      6'h27, 6'h18: dec6 = 6'h20;
      6'h1d, 6'h22: dec6 = 6'h21;
      6'h2d, 6'h12: dec6 = 6'h22;
      6'h31:        dec6 = 6'h23;
      6'h35, 6'h0a: dec6 = 6'h24;
      6'h29:        dec6 = 6'h25;
      6'h19:        dec6 = 6'h26;
      6'h38, 6'h07: dec6 = 6'h27;
      6'h39, 6'h06: dec6 = 6'h28;
      6'h25:        dec6 = 6'h29;
      6'h15:        dec6 = 6'h2a;
      6'h34:        dec6 = 6'h2b;
      6'h0d:        dec6 = 6'h2c;
      6'h2c:        dec6 = 6'h2d;
      6'h1c:        dec6 = 6'h2e;
      6'h17, 6'h28: dec6 = 6'h2f;
      6'h1b, 6'h24: dec6 = 6'h30;
      6'h23:        dec6 = 6'h31;
      6'h13:        dec6 = 6'h32;
      6'h32:        dec6 = 6'h33;
      6'h0b:        dec6 = 6'h34;
      6'h2a:        dec6 = 6'h35;
      6'h1a:        dec6 = 6'h36;
      6'h3a, 6'h05: dec6 = 6'h37;
      6'h33, 6'h0c: dec6 = 6'h38;
      6'h26:        dec6 = 6'h39;
      6'h16:        dec6 = 6'h3a;
      6'h36, 6'h09: dec6 = 6'h3b;
      6'h0e:        dec6 = 6'h3c;
      6'h2e, 6'h11: dec6 = 6'h3d;
      6'h1e, 6'h21: dec6 = 6'h3e;
      6'h2b, 6'h14: dec6 = 6'h3f;
      default:      dec6 = 6'h00;
    endcase
  endfunction

  // 4b sub-block fghj to HGF, top bit flags a legal code
  function automatic logic [3:0] dec4(input logic [3:0] c);
    case (c)
      4'hb, 4'h4: dec4 = 4'h8;
      4'h9:       dec4 = 4'h9;
      4'h5:       dec4 = 4'ha;
      4'hc, 4'h3: dec4 = 4'hb;
      4'hd, 4'h2: dec4 = 4'hc;
      4'ha:       dec4 = 4'hd;
      4'h6:       dec4 = 4'he;
      4'he, 4'h1: dec4 = 4'hf;
      4'h7, 4'h8: dec4 = 4'hf;
      default:    dec4 = 4'h0;
    endcase
  endfunction

  // Whole symbol: bit 8 flags a legal data symbol, bits 7:0 the byte
  function automatic logic [8:0] dec10(input logic [9:0] s);
    logic [5:0] lo;
    logic [3:0] hi;
    lo = dec6(s[9:4]);
    hi = dec4(s[3:0]);
    dec10 = {lo[5] & hi[3], hi[2:0], lo[4:0]};
  endfunction

  // Comma in either running disparity
  function automatic logic is_comma(input logic [9:0] s);
    is_comma = (s == `DDM_COMMA_NEG) || (s == `DDM_COMMA_POS);
  endfunction

  // Differential pairs: even bit is the input, odd bit its inverse
  function automatic logic [7:0] mirror4(input logic [3:0] v);
    mirror4 = {~v[3], v[3], ~v[2], v[2], ~v[1], v[1], ~v[0], v[0]};
  endfunction

  // Unsigned 8 by 8 product, operands widened first so no bit is lost
  function automatic logic [15:0] mul8(input logic [7:0] a, input logic [7:0] b);
    mul8 = {8'h00, a} * {8'h00, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] pins_raw;
  logic [7:0] pins_meta_r;
  logic [7:0] pins_s_r;

  assign pins_raw = {bidir_drive_in, sel_dec_unreg_in, sel_dec_reg_in, sel_prod_gated_in,
                     sel_prod_in, sel_status_in, line_b_in, line_a_in};

  // Two flip-flops ahead of any logic except the reset mirror, which takes the raw pins
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_meta_r <= 8'h00;
      pins_s_r    <= 8'h00;
    end else begin
      pins_meta_r <= pins_raw;
      pins_s_r    <= pins_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane decoders, index 0 is lane A, 1 is lane B

  ddm_lane_state_t lane_st_r [2];
  logic [9:0]      sym_r     [2];
  logic [3:0]      cnt_r     [2];
  logic [7:0]      byte_r    [2];
  logic [9:0]      sym_nxt   [2];
  logic [8:0]      dec_w     [2];
  logic [1:0]      comma_w;
  logic [1:0]      sym_end_w;
  logic [1:0]      locked_w;
  logic [1:0]      new_data_w;
  logic [1:0]      lock_evt_w;
  logic [1:0]      lost_evt_w;

  // Next window, its decode and the per-lane events
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sym_nxt[i]    = {sym_r[i][8:0], pins_s_r[i]};
      dec_w[i]      = dec10(sym_nxt[i]);
      comma_w[i]    = is_comma(sym_nxt[i]);
      locked_w[i]   = (lane_st_r[i] == DDM_LOCKED);
      sym_end_w[i]  = locked_w[i] && (cnt_r[i] == `DDM_SYM_LAST);
      lock_evt_w[i] = !locked_w[i] && comma_w[i];
      new_data_w[i] = sym_end_w[i] && !comma_w[i] && dec_w[i][8];
      lost_evt_w[i] = sym_end_w[i] && !comma_w[i] && !dec_w[i][8];
    end
  end

  // Alignment, symbol counting and byte capture
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 2; i++) begin
        lane_st_r[i] <= DDM_HUNT;
        sym_r[i]     <= 10'h000;
        cnt_r[i]     <= 4'h0;
        byte_r[i]    <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        sym_r[i] <= sym_nxt[i];
        cnt_r[i] <= (lock_evt_w[i] || sym_end_w[i]) ? 4'h0 : cnt_r[i] + 4'h1;
        case (lane_st_r[i])
          DDM_HUNT:   if (lock_evt_w[i]) lane_st_r[i] <= DDM_LOCKED;
          DDM_LOCKED: if (lost_evt_w[i]) lane_st_r[i] <= DDM_HUNT;
          default:    lane_st_r[i] <= DDM_HUNT;
        endcase
        // A comma in lock leaves the byte alone
        if (new_data_w[i]) byte_r[i] <= dec_w[i][7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier

  logic [15:0] prod_w;
  logic [15:0] prod_gated_r;
  logic [7:0]  op_a_w;
  logic [7:0]  op_b_w;

  assign prod_w = mul8(byte_r[0], byte_r[1]);

  // Operands as they will stand after this edge
  assign op_a_w = new_data_w[0] ? dec_w[0][7:0] : byte_r[0];
  assign op_b_w = new_data_w[1] ? dec_w[1][7:0] : byte_r[1];

  // Product snapshot taken only when a lane accepts new data
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) prod_gated_r <= 16'h0000;
    else if (|new_data_w) prod_gated_r <= mul8(op_a_w, op_b_w);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output view selection

  ddm_view_t  view_w;
  logic [7:0] view_lo_w;
  logic [7:0] view_hi_w;
  logic [7:0] out_lo_r;
  logic [7:0] out_hi_r;
  logic       drive_r;

  // Lower selection pin wins; registered bytes when none is set
  assign view_w = pins_s_r[2] ? DDM_VIEW_STATUS :
                  pins_s_r[3] ? DDM_VIEW_PROD :
                  pins_s_r[4] ? DDM_VIEW_PROD_GATED :
                  pins_s_r[5] ? DDM_VIEW_DEC_REG :
                  pins_s_r[6] ? DDM_VIEW_DEC_UNREG : DDM_VIEW_DEC_REG;

  // Low byte to the outputs, high byte to the bidirectional pins
  always_comb begin
    case (view_w)
      DDM_VIEW_STATUS:     {view_hi_w, view_lo_w} = {14'h0000, locked_w};
      DDM_VIEW_PROD:       {view_hi_w, view_lo_w} = prod_w;
      DDM_VIEW_PROD_GATED: {view_hi_w, view_lo_w} = prod_gated_r;
      DDM_VIEW_DEC_UNREG:  {view_hi_w, view_lo_w} = {dec_w[1][7:0], dec_w[0][7:0]};
      default:             {view_hi_w, view_lo_w} = {byte_r[1], byte_r[0]};
    endcase
  end

  // Output registers
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_lo_r <= 8'h00;
      out_hi_r <= 8'h00;
      drive_r  <= 1'b0;
    end else begin
      out_lo_r <= view_lo_w;
      out_hi_r <= view_hi_w;
      drive_r  <= pins_s_r[7];
    end
  end

  // Reset mirrors raw pins; afterwards the registered view shows
  assign out_pins_out   = arst_n_in ? out_lo_r : mirror4(pins_raw[3:0]);
  assign bidir_out      = arst_n_in ? out_hi_r : mirror4(pins_raw[7:4]);
  assign bidir_oe_n_out = arst_n_in ? {8{~drive_r}} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave with one wait state

  logic [3:0]  status_r;
  logic [3:0]  mask_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_w;
  logic [3:0]  byte_addr_w;
  logic        req_w;
  logic        rd_done_w;
  logic        wr_done_w;
  logic [3:0]  evt_w;
  logic [3:0]  status_clr_w;

  assign byte_addr_w = {avs_address_in, 2'b00};
  assign req_w       = avs_read_in | avs_write_in;
  assign rd_done_w   = avs_read_in & ack_r;
  assign wr_done_w   = avs_write_in & ack_r;
  assign evt_w       = {lost_evt_w[1], lock_evt_w[1], lost_evt_w[0], lock_evt_w[0]};

  // A read clears only the bits it returned, so an event during the wait survives
  assign status_clr_w = (rd_done_w && byte_addr_w == `DDM_OFS_STATUS) ? rdata_r[3:0] : 4'h0;

  // Read mux; unmapped words read zero
  assign rdata_w = (byte_addr_w == `DDM_OFS_STATUS) ? {28'h0000000, status_r} :
                   (byte_addr_w == `DDM_OFS_MASK)   ? {28'h0000000, mask_r} :
                   (byte_addr_w == `DDM_OFS_DATA)   ? {14'h0000, locked_w, byte_r[1], byte_r[0]} :
                   (byte_addr_w == `DDM_OFS_PROD)   ? {16'h0000, prod_w} : 32'h00000000;

  // First request cycle waits, data captured for the second
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= req_w & ~ack_r;
      rdata_r <= (avs_read_in & ~ack_r) ? rdata_w : 32'h00000000;
    end
  end

  // Sticky events, read clears, a new event wins over the clear
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_r <= `DDM_STATUS_RST;
      mask_r   <= `DDM_MASK_RST;
    end else begin
      status_r <= (status_r & ~status_clr_w) | evt_w;
      if (wr_done_w && byte_addr_w == `DDM_OFS_MASK && avs_byteenable_in[0])
        mask_r <= avs_writedata_in[3:0];
    end
  end

  assign avs_waitrequest_out = req_w & ~ack_r;
  assign avs_readdata_out    = rdata_r;
  assign irq_out             = |(status_r & mask_r);

endmodule

// File: testbench/ddm_top_asserts.sv
// Port assertions for the dual decoder block
`timescale 1ns/1ps
module ddm_top_asserts (
  input wire logic        clock_in,
  input wire logic        arst_n_in,
  input wire logic        sel_status_in,
  input wire logic        bidir_drive_in,
  input wire logic [7:0]  out_pins_out,
  input wire logic [7:0]  bidir_out,
  input wire logic [7:0]  bidir_oe_n_out,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out
);
  // One domain, checks sleep through reset
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  wire req;
  assign req = avs_read_in | avs_write_in;
  ////////////////////////////////////////
  // Bidir enables move as one and follow the drive input
  oe_uniform_a: assert property (bidir_oe_n_out == 8'h00 || bidir_oe_n_out == 8'hff)
    else $error("bidir enables disagree");
  oe_follow_a: assert property ($stable(bidir_drive_in) [*5]
    |-> bidir_oe_n_out == {8{~bidir_drive_in}}) else $error("enables ignore drive");
  oe_cause_a: assert property ($past(arst_n_in, 5) && $changed(bidir_oe_n_out)
    |-> $past(bidir_drive_in, 2) != $past(bidir_drive_in, 5)) else $error("enables moved alone");
  // Status view clears everything but the two valid flags
  status_view_a: assert property (sel_status_in [*5]
    |-> bidir_out == 8'h00 && out_pins_out[7:2] == 6'h00) else $error("status view wrong");
  ////////////////////////////////////////
  // One wait state per access, read data only at completion
  wait_first_a: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("no wait state");
  wait_one_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait state too long");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest_out)
    else $error("wait while idle");
  rdata_zero_a: assert property (!(avs_read_in && !avs_waitrequest_out)
    |-> avs_readdata_out == 32'h0) else $error("read data outside completion");
endmodule

bind ddm_top ddm_top_asserts chk_u (.clock_in, .arst_n_in, .sel_status_in, .bidir_drive_in,
  .out_pins_out, .bidir_out, .bidir_oe_n_out, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out);

// File: testbench/ddm_enc_model.sv
// Serial transmitter model driving both encoded lanes
`timescale 1ns/1ps
`include "ddm_consts.svh"
module ddm_enc_model (
  input  wire logic clock_in,
  output logic      line_a_out,
  output logic      line_b_out
);
  logic [9:0] shift_a_r = `DDM_COMMA_NEG;
  logic [9:0] shift_b_r = `DDM_COMMA_NEG;
  logic [9:0] next_a    = `DDM_COMMA_NEG;
  logic [9:0] next_b    = `DDM_COMMA_NEG;
  logic [9:0] fill      = `DDM_COMMA_NEG;
  logic [3:0] bit_r     = 4'h0;
  logic       req_r     = 1'b0;
  logic       ack_r     = 1'b0;
  logic       disp_r    = 1'b0;
  wire  [9:0] idle;
  // Idle commas alternate disparity; bit a leaves first
  assign idle = (fill == `DDM_COMMA_NEG && disp_r) ? `DDM_COMMA_POS : fill;
  assign line_a_out = shift_a_r[9];
  assign line_b_out = shift_b_r[9];
  // Back to back symbols, one bit per clock
  always @(posedge clock_in) begin
    if (bit_r == `DDM_SYM_LAST) begin
      bit_r     <= 4'h0;
      shift_a_r <= (req_r != ack_r) ? next_a : idle;
      shift_b_r <= (req_r != ack_r) ? next_b : idle;
      disp_r    <= ~disp_r;
      ack_r     <= req_r;
    end else begin
      bit_r     <= bit_r + 4'h1;
      shift_a_r <= shift_a_r << 1;
      shift_b_r <= shift_b_r << 1;
    end
  end
  // Queue one symbol pair by toggling the request, return once it is loaded
  task automatic send(input logic [9:0] sym_a, input logic [9:0] sym_b);
    next_a <= sym_a;
    next_b <= sym_b;
    req_r  <= ~req_r;
    @(posedge clock_in);
    wait (ack_r == req_r);
  endtask
endmodule

// File: testbench/ddm_top_tb.sv
// Self-checking bench for the dual decoder block
`timescale 1ns/1ps
`include "ddm_consts.svh"
module ddm_top_tb;
  localparam logic [9:0] D3_1 = 10'h319; // Byte 8'h23
  localparam logic [9:0] D5_2 = 10'h295; // Byte 8'h45
  localparam logic [9:0] D2_3 = 10'h2dc; // Byte 8'h62
  localparam logic [9:0] D0_0 = 10'h274; // Byte 8'h00
  logic        clock_in  = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        drive     = 1'b1;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [1:0]  adr       = 2'h0;
  logic [31:0] wdata     = 32'h0;
  logic [4:0]  sel       = 5'h15;
  logic        line_a, line_b, irq, waitreq;
  logic [7:0]  out_pins, bidir, oe_n;
  logic [31:0] rdata, q;
  int          miscompares = 0;
  int          comparisons = 0;
  ////////////////////////////////////////
  ddm_top dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in), .line_a_in(line_a),
    .line_b_in(line_b), .sel_status_in(sel[0]), .sel_prod_in(sel[1]),
    .sel_prod_gated_in(sel[2]), .sel_dec_reg_in(sel[3]), .sel_dec_unreg_in(sel[4]),
    .bidir_drive_in(drive), .out_pins_out(out_pins), .bidir_out(bidir), .bidir_oe_n_out(oe_n),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .irq_out(irq));
  ddm_enc_model enc_u (.clock_in(clock_in), .line_a_out(line_a), .line_b_out(line_b));
  // 125 MHz clock
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clock_in);
    rd    <= ~w;
    wr    <= w;
    adr   <= a;
    wdata <= d;
    do @(posedge clock_in); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock_in);
  endtask
  // Choose a view, let it settle, compare both bytes
  task automatic view(input logic [4:0] s, input logic [15:0] exp);
    sel <= s;
    repeat (6) @(posedge clock_in);
    check("pins", {16'h0, exp}, {16'h0, bidir, out_pins});
  endtask
  task automatic sym(input logic [9:0] a, input logic [9:0] b);
    enc_u.send(a, b);
    repeat (24) @(posedge clock_in);
  endtask
  function automatic logic [31:0] pairs(input logic [7:0] v);
    pairs = 32'h0;
    for (int i = 0; i < 8; i++) pairs[2*i +: 2] = {~v[i], v[i]};
  endfunction
  ////////////////////////////////////////
  task automatic t_mirror();
    repeat (3) @(posedge clock_in);
    check("mirror", pairs({drive, sel, line_b, line_a}), {16'h0, bidir, out_pins});
    check("oe", 32'h0, {24'h0, oe_n});
    sel   <= 5'h0a;
    drive <= 1'b0;
    repeat (3) @(posedge clock_in);
    check("mirror", pairs({drive, sel, line_b, line_a}), {16'h0, bidir, out_pins});
    $display("mirror test done");
  endtask
  task automatic t_oe();
    repeat (2) @(posedge clock_in);
    check("oe", 32'hff, {24'h0, oe_n});
    drive <= 1'b1;
    repeat (6) @(posedge clock_in);
    check("oe", 32'h0, {24'h0, oe_n});
    $display("oe test done");
  endtask
  task automatic t_lock();
    repeat (24) @(posedge clock_in);
    view(5'h11, 16'h0003);
    sym(D3_1, D5_2);
    view(5'h08, 16'h4523);
    view(5'h02, 16'h096f);
    view(5'h0c, 16'h096f);
    bus(1'b0, 2'h2, 32'h0);
    check("data", 32'h0003_4523, q);
    bus(1'b0, 2'h3, 32'h0);
    check("product", 32'h0000_096f, q);
    $display("lock test done");
  endtask
  task automatic t_comma();
    sym(`DDM_COMMA_POS, `DDM_COMMA_NEG);
    view(5'h18, 16'h4523);
    view(5'h01, 16'h0003);
    sym(D2_3, D3_1);
    view(5'h04, 16'h0d66);
    view(5'h08, 16'h2362);
    $display("comma test done");
  endtask
  task automatic t_irq();
    check("irq", 32'h0, {31'h0, irq});
    bus(1'b1, 2'h1, 32'hf);
    check("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 2'h0, 32'hf);
    bus(1'b0, 2'h0, 32'h0);
    check("status", 32'h5, q);
    check("irq", 32'h0, {31'h0, irq});
    bus(1'b0, 2'h1, 32'h0);
    check("mask", 32'hf, q);
    $display("irq test done");
  endtask
  // Bad symbol on lane A while data fills the idle gaps
  task automatic t_lost();
    enc_u.fill <= D0_0;
    sym(10'h000, D0_0);
    view(5'h01, 16'h0002);
    check("irq", 32'h1, {31'h0, irq});
    bus(1'b0, 2'h0, 32'h0);
    check("status", 32'h2, q);
    view(5'h08, 16'h0062);
    enc_u.fill <= `DDM_COMMA_NEG;
    repeat (30) @(posedge clock_in);
    view(5'h01, 16'h0003);
    bus(1'b0, 2'h0, 32'h0);
    check("status", 32'h1, q);
    $display("lost test done");
  endtask
  // Unregistered view decodes the live window: one aligned cycle in ten
  task automatic t_unreg();
    int hits = 0;
    @(posedge clock_in);
    enc_u.fill <= D2_3;
    sel        <= 5'h10;
    repeat (30) @(posedge clock_in);
    repeat (10) begin
      @(posedge clock_in);
      if ({bidir, out_pins} === 16'h6262) hits++;
    end
    check("unreg hits", 32'h1, hits);
    view(5'h08, 16'h6262);
    $display("unreg test done");
  endtask
  ////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence, reset held for the first ten clocks
  initial begin
    t_mirror();
    repeat (4) @(posedge clock_in);
    arst_n_in <= 1'b1;
    t_oe();
    t_lock();
    t_comma();
    t_irq();
    t_lost();
    t_unreg();
    results();
  end
  // Watchdog far beyond the expected run
  initial begin
    #20us;
    miscompares++;
    results();
  end
endmodule
